// *** sca_pkg.sv ***
// constants, register map and field layout of the seconds counter with alarm
`default_nettype none
package sca_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ADDR_COUNT      = 8'h00;
    localparam logic [7:0] ADDR_ALARM      = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_TRIM       = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;
    localparam int ST_ALARM_FLAG  = 0;
    localparam int ST_TICK_FLAG   = 1;
    localparam int ST_ALARM_EN    = 2;
    localparam int ST_TICK_EN     = 3;
    localparam int ST_W           = 4;
    localparam int INT_DIV_LSB    = 0;
    localparam int INT_DIV_W      = 16;
    localparam int DEL_LSB        = 16;
    localparam int DEL_W          = 10;
    localparam int TRIM_W         = 26;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 26'h0000000;
    localparam logic [DEL_W-1:0]  TRIM_INTERVAL_LAST = 10'h3fe;
    localparam int IRQ_W          = 2;
    localparam int IRQ_ALARM      = 0;
    localparam int IRQ_TICK       = 1;
endpackage
`default_nettype wire

// *** sca_rtc.sv ***
// seconds counter with alarm compare, status flags, trimmed tick divider and register port
`default_nettype none
module sca_rtc (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        osc_32k_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    output logic             alarm_req_o,
    output logic             tick_req_o,
    output logic             irq_o
);
    logic [2:0]  osc_sync_r;
    logic        osc_edge;
    logic [31:0] count_r;
    logic [31:0] alarm_r;
    logic [31:0] pend_val_r;
    logic        pend_r;
    logic [sca_pkg::TRIM_W-1:0]    trim_r;
    logic [sca_pkg::INT_DIV_W-1:0] div_r;
    logic [sca_pkg::DEL_W-1:0]     interval_r;
    logic [sca_pkg::DEL_W-1:0]     del_left_r;
    logic        tick_pulse;
    logic        step_en;
    logic        load_now;
    logic [31:0] count_inc;
    logic        alarm_hit;
    logic        alarm_flag_r;
    logic        tick_flag_r;
    logic        alarm_en_r;
    logic        tick_en_r;
    logic [sca_pkg::IRQ_W-1:0] irq_stat_r;
    logic [sca_pkg::IRQ_W-1:0] irq_mask_r;
    logic [sca_pkg::IRQ_W-1:0] irq_ev;
    logic [31:0] rd_data_r;
    logic        alarm_req_r;
    logic        tick_req_r;
    logic        irq_r;
    logic        wr_count;
    logic        wr_status;

    assign wr_count  = wr_i && (addr_i == sca_pkg::ADDR_COUNT);
    assign wr_status = wr_i && (addr_i == sca_pkg::ADDR_STATUS);

    // oscillator input brought into the processor clock domain
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            osc_sync_r <= 3'h0;
        else
            osc_sync_r <= {osc_sync_r[1:0], osc_32k_i};
    end
    assign osc_edge = osc_sync_r[1] && !osc_sync_r[2];

    // clocks being deleted do not advance the divider
    assign step_en    = osc_edge && (del_left_r == '0);
    assign tick_pulse = step_en && (div_r == trim_r[sca_pkg::INT_DIV_LSB +: sca_pkg::INT_DIV_W]);
    assign load_now   = osc_edge && pend_r;
    assign count_inc  = count_r + 32'h00000001;
    assign alarm_hit  = tick_pulse && !load_now && (count_inc == alarm_r) && alarm_en_r;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            trim_r <= sca_pkg::TRIM_RESET;
        else if (wr_i && addr_i == sca_pkg::ADDR_TRIM)
            trim_r <= wr_data_i[sca_pkg::TRIM_W-1:0];
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            div_r <= '0;
        else if (tick_pulse)
            div_r <= '0;
        else if (step_en)
            div_r <= div_r + 16'h0001;
    end

    // every interval of ticks, hold the divider for the programmed delete count
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            interval_r <= '0;
            del_left_r <= '0;
        end
        else
        begin
            if (tick_pulse)
            begin
                if (interval_r == sca_pkg::TRIM_INTERVAL_LAST)
                begin
                    interval_r <= '0;
                    del_left_r <= trim_r[sca_pkg::DEL_LSB +: sca_pkg::DEL_W];
                end
                else
                    interval_r <= interval_r + 10'h001;
            end
            else if (osc_edge && del_left_r != '0)
                del_left_r <= del_left_r - 10'h001;
        end
    end

    // counter and alarm hold through every reset
    always_ff @(posedge ref_clk_i)
    begin
        if (load_now)
            count_r <= pend_val_r;
        else if (tick_pulse)
            count_r <= count_inc;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (wr_i && addr_i == sca_pkg::ADDR_ALARM)
            alarm_r <= wr_data_i;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pend_r     <= 1'b0;
            pend_val_r <= 32'h00000000;
        end
        else if (load_now)
            pend_r <= 1'b0;
        else if (wr_count && !pend_r)
        begin
            pend_r     <= 1'b1;
            pend_val_r <= wr_data_i;
        end
    end

    // status flags: hardware set wins over write-one clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            alarm_flag_r <= 1'b0;
            tick_flag_r  <= 1'b0;
            alarm_en_r   <= 1'b0;
            tick_en_r    <= 1'b0;
        end
        else
        begin
            if (alarm_hit)
                alarm_flag_r <= 1'b1;
            else if (wr_status && wr_data_i[sca_pkg::ST_ALARM_FLAG])
                alarm_flag_r <= 1'b0;
            if (tick_pulse)
                tick_flag_r <= 1'b1;
            else if (wr_status && wr_data_i[sca_pkg::ST_TICK_FLAG])
                tick_flag_r <= 1'b0;
            if (wr_status)
            begin
                alarm_en_r <= wr_data_i[sca_pkg::ST_ALARM_EN];
                tick_en_r  <= wr_data_i[sca_pkg::ST_TICK_EN];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            alarm_req_r <= 1'b0;
            tick_req_r  <= 1'b0;
        end
        else
        begin
            alarm_req_r <= alarm_flag_r && alarm_en_r;
            tick_req_r  <= tick_flag_r && tick_en_r;
        end
    end

    // sticky interrupt status, cleared by reading it; new events win
    assign irq_ev[sca_pkg::IRQ_ALARM] = alarm_hit;
    assign irq_ev[sca_pkg::IRQ_TICK]  = tick_pulse;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            irq_stat_r <= '0;
        else if (rd_i && addr_i == sca_pkg::ADDR_IRQ_STAT)
            irq_stat_r <= irq_ev;
        else
            irq_stat_r <= irq_stat_r | irq_ev;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            irq_mask_r <= '0;
        else if (wr_i && addr_i == sca_pkg::ADDR_IRQ_MASK)
            irq_mask_r <= wr_data_i[sca_pkg::IRQ_W-1:0];
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            irq_r <= 1'b0;
        else
            irq_r <= |(irq_stat_r & irq_mask_r);
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_data_r <= 32'h00000000;
        else if (rd_i)
        begin
            case (addr_i)
                sca_pkg::ADDR_COUNT:    rd_data_r <= count_r;
                sca_pkg::ADDR_ALARM:    rd_data_r <= alarm_r;
                sca_pkg::ADDR_STATUS:   rd_data_r <= {28'h0000000, tick_en_r, alarm_en_r,
                                                      tick_flag_r, alarm_flag_r};
                sca_pkg::ADDR_TRIM:     rd_data_r <= {6'h00, trim_r};
                sca_pkg::ADDR_IRQ_STAT: rd_data_r <= {30'h00000000, irq_stat_r};
                sca_pkg::ADDR_IRQ_MASK: rd_data_r <= {30'h00000000, irq_mask_r};
                default:                rd_data_r <= 32'h00000000;
            endcase
        end
        else
            rd_data_r <= 32'h00000000;
    end

    assign rd_data_o   = rd_data_r;
    assign alarm_req_o = alarm_req_r;
    assign tick_req_o  = tick_req_r;
    assign irq_o       = irq_r;

    sequence s_plain_tick;
        tick_pulse && !load_now;
    endsequence

    sequence s_status_read;
        rd_i && addr_i == sca_pkg::ADDR_STATUS;
    endsequence

    property p_count_step;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_plain_tick |=> count_r == $past(count_r) + 32'h00000001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step on tick");

    property p_load;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        load_now |=> count_r == $past(pend_val_r) && !pend_r;
    endproperty
    a_load: assert property (p_load) else $error("pending counter write not loaded");

    property p_drop_write;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        pend_r && wr_count && !load_now |=> pend_val_r == $past(pend_val_r);
    endproperty
    a_drop_write: assert property (p_drop_write) else $error("write during pending load not dropped");

    property p_alarm_set;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_plain_tick ##0 (count_inc == alarm_r && alarm_en_r) |=> alarm_flag_r ##1 alarm_req_o;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm match not flagged");

    property p_alarm_cause;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(alarm_flag_r) |-> $past(tick_pulse && !load_now && alarm_en_r) && count_r == alarm_r;
    endproperty
    a_alarm_cause: assert property (p_alarm_cause) else $error("alarm flag without match");

    property p_tick_flag;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        tick_pulse |=> tick_flag_r;
    endproperty
    a_tick_flag: assert property (p_tick_flag) else $error("tick did not set flag");

    property p_w1c;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_status && wr_data_i[sca_pkg::ST_TICK_FLAG] && !tick_pulse |=> !tick_flag_r;
    endproperty
    a_w1c: assert property (p_w1c) else $error("tick flag not cleared by write one");

    property p_req_gate;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 tick_req_o == $past(tick_flag_r && tick_en_r);
    endproperty
    a_req_gate: assert property (p_req_gate) else $error("tick request not gated by enable");

    property p_reserved_zero;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_status_read |=> rd_data_o[31:4] == 28'h0000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits not zero");

    property p_trim_zero;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        trim_r == '0 && osc_edge |-> tick_pulse;
    endproperty
    a_trim_zero: assert property (p_trim_zero) else $error("zero trim did not pass every clock");

    property p_div_wrap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        tick_pulse |=> div_r == '0;
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider not reset at match");

    property p_read_count;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        rd_i && addr_i == sca_pkg::ADDR_COUNT |=> rd_data_o == $past(count_r);
    endproperty
    a_read_count: assert property (p_read_count) else $error("counter read mismatch");

    property p_edge_once;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        osc_edge |=> !osc_edge;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("oscillator edge seen twice");

    property p_alarm_req_on;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        alarm_flag_r && alarm_en_r |=> alarm_req_o;
    endproperty
    a_alarm_req_on: assert property (p_alarm_req_on) else $error("enabled alarm flag gave no request");

    property p_alarm_req_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !(alarm_flag_r && alarm_en_r) |=> !alarm_req_o;
    endproperty
    a_alarm_req_off: assert property (p_alarm_req_off) else $error("alarm request without enabled flag");

    property p_w1c_alarm;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_status && wr_data_i[sca_pkg::ST_ALARM_FLAG] && !alarm_hit |=> !alarm_flag_r;
    endproperty
    a_w1c_alarm: assert property (p_w1c_alarm) else $error("alarm flag not cleared by write one");

    property p_flag_keep;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_status && !wr_data_i[sca_pkg::ST_TICK_FLAG] && tick_flag_r |=> tick_flag_r;
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("write zero changed tick flag");

    property p_status_flags;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_status_read |=> rd_data_o[sca_pkg::ST_ALARM_FLAG] == $past(alarm_flag_r)
                          && rd_data_o[sca_pkg::ST_TICK_FLAG] == $past(tick_flag_r);
    endproperty
    a_status_flags: assert property (p_status_flags) else $error("status flag bits misplaced");

    property p_status_enables;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_status_read |=> rd_data_o[sca_pkg::ST_ALARM_EN] == $past(alarm_en_r)
                          && rd_data_o[sca_pkg::ST_TICK_EN] == $past(tick_en_r);
    endproperty
    a_status_enables: assert property (p_status_enables) else $error("status enable bits misplaced");

    property p_read_alarm;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        rd_i && addr_i == sca_pkg::ADDR_ALARM |=> rd_data_o == $past(alarm_r);
    endproperty
    a_read_alarm: assert property (p_read_alarm) else $error("alarm value read mismatch");

    property p_read_idle;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !rd_i |=> rd_data_o == 32'h00000000;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not zero without read");

    property p_irq_sticky;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        irq_stat_r[sca_pkg::IRQ_TICK] && !(rd_i && addr_i == sca_pkg::ADDR_IRQ_STAT) |=> irq_stat_r[sca_pkg::IRQ_TICK];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt status lost without read");

    property p_div_step;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        step_en && !tick_pulse |=> div_r == $past(div_r) + 16'h0001;
    endproperty
    a_div_step: assert property (p_div_step) else $error("divider did not count oscillator edge");
endmodule
`default_nettype wire

// *** sca_testbench.sv ***
// self-checking bench for the seconds counter with alarm, driven over its register port
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk_i;
    logic        rst_n_i;
    logic        osc_32k_i;
    logic [7:0]  addr_i;
    logic [31:0] wr_data_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rd_data_o;
    logic        alarm_req_o;
    logic        tick_req_o;
    logic        irq_o;
    int          bad_count;
    int          n_checks;
    int          cyc = 0;
    logic [31:0] rdv;

    sca_rtc dut_u (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .osc_32k_i   (osc_32k_i),
        .addr_i      (addr_i),
        .wr_data_i   (wr_data_i),
        .wr_i        (wr_i),
        .rd_i        (rd_i),
        .rd_data_o   (rd_data_o),
        .alarm_req_o (alarm_req_o),
        .tick_req_o  (tick_req_o),
        .irq_o       (irq_o)
    );

    initial ref_clk_i = 1'b0;
    always #4 ref_clk_i = ~ref_clk_i;

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // run is far shorter than this; a hang ends here
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            $display("Error timeout expected 0 seen %0d", cyc);
            conclude();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        wr_i      <= 1'b1;
        addr_i    <= a;
        wr_data_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rd_data_o;
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(what, v, exp);
    endtask

    // one oscillator period, then time for flags and requests to settle
    task automatic osc_pulse();
        @(posedge ref_clk_i);
        osc_32k_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        osc_32k_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
    endtask

    initial
    begin
        bad_count = 0;
        n_checks  = 0;
        rst_n_i   = 1'b0;
        osc_32k_i = 1'b0;
        addr_i    = 8'h00;
        wr_data_i = 32'h00000000;
        wr_i      = 1'b0;
        rd_i      = 1'b0;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rdchk("status", sca_pkg::ADDR_STATUS, 32'h00000000);
        rdchk("trim", sca_pkg::ADDR_TRIM, 32'h00000000);
        // second write while the first is pending must be dropped
        wr(sca_pkg::ADDR_COUNT, 32'h00000010);
        wr(sca_pkg::ADDR_COUNT, 32'h00000055);
        osc_pulse();
        rdchk("count", sca_pkg::ADDR_COUNT, 32'h00000010);
        wr(sca_pkg::ADDR_COUNT, 32'h00000020);
        osc_pulse();
        rdchk("count", sca_pkg::ADDR_COUNT, 32'h00000020);
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("rd_data idle", rd_data_o, 32'h00000000);
        wr(sca_pkg::ADDR_ALARM, 32'h00000021);
        rdchk("alarm", sca_pkg::ADDR_ALARM, 32'h00000021);
        wr(sca_pkg::ADDR_STATUS, 32'h0000000f);
        rdchk("status", sca_pkg::ADDR_STATUS, 32'h0000000c);
        osc_pulse();
        rdchk("count", sca_pkg::ADDR_COUNT, 32'h00000021);
        rdchk("status", sca_pkg::ADDR_STATUS, 32'h0000000f);
        chk("alarm_req", {31'h0, alarm_req_o}, 32'h00000001);
        chk("tick_req", {31'h0, tick_req_o}, 32'h00000001);
        wr(sca_pkg::ADDR_STATUS, 32'hfffffffc);
        rdchk("status", sca_pkg::ADDR_STATUS, 32'h0000000f);
        wr(sca_pkg::ADDR_STATUS, 32'h0000000d);
        repeat (3) @(posedge ref_clk_i);
        rdchk("status", sca_pkg::ADDR_STATUS, 32'h0000000e);
        chk("alarm_req", {31'h0, alarm_req_o}, 32'h00000000);
        chk("tick_req", {31'h0, tick_req_o}, 32'h00000001);
        // match with alarm disabled leaves the alarm flag clear
        wr(sca_pkg::ADDR_STATUS, 32'h00000008);
        wr(sca_pkg::ADDR_ALARM, 32'h00000022);
        osc_pulse();
        rdchk("count", sca_pkg::ADDR_COUNT, 32'h00000022);
        rdchk("status", sca_pkg::ADDR_STATUS, 32'h0000000a);
        // interrupt: status sticky, masked, then read-cleared
        chk("irq masked", {31'h0, irq_o}, 32'h00000000);
        wr(sca_pkg::ADDR_IRQ_MASK, 32'h00000001);
        repeat (3) @(posedge ref_clk_i);
        chk("irq", {31'h0, irq_o}, 32'h00000001);
        rdchk("irq mask", sca_pkg::ADDR_IRQ_MASK, 32'h00000001);
        rdchk("irq status", sca_pkg::ADDR_IRQ_STAT, 32'h00000003);
        repeat (3) @(posedge ref_clk_i);
        chk("irq cleared", {31'h0, irq_o}, 32'h00000000);
        rdchk("irq status", sca_pkg::ADDR_IRQ_STAT, 32'h00000000);
        rdchk("unmapped", 8'h18, 32'h00000000);
        // hard reset mid-run keeps the count but clears the status
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rdchk("count", sca_pkg::ADDR_COUNT, 32'h00000022);
        rdchk("status", sca_pkg::ADDR_STATUS, 32'h00000000);
        rdchk("trim", sca_pkg::ADDR_TRIM, 32'h00000000);
        // divide by three: tick on the third oscillator edge only
        wr(sca_pkg::ADDR_TRIM, 32'hfc000002);
        rdchk("trim", sca_pkg::ADDR_TRIM, 32'h00000002);
        osc_pulse();
        osc_pulse();
        rdchk("count", sca_pkg::ADDR_COUNT, 32'h00000022);
        rdchk("status", sca_pkg::ADDR_STATUS, 32'h00000000);
        osc_pulse();
        rdchk("count", sca_pkg::ADDR_COUNT, 32'h00000023);
        rdchk("status", sca_pkg::ADDR_STATUS, 32'h00000002);
        chk("tick_req off", {31'h0, tick_req_o}, 32'h00000000);
        wr(sca_pkg::ADDR_STATUS, 32'h00000002);
        rdchk("status", sca_pkg::ADDR_STATUS, 32'h00000000);
        conclude();
    end
endmodule
`default_nettype wire
